/* File: common/dsp_datapath_pkg.sv */
// Types shared by the datapath modules
package dsp_datapath_pkg;
    typedef enum logic [2:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_HOLD
    } alu_op_t;
    typedef enum logic [1:0] {
        SRC_DATA, SRC_IMM, SRC_PROD
    } operand_src_t;
    typedef enum logic [1:0] {
        AUX_NONE, AUX_INC, AUX_DEC, AUX_LOAD
    } aux_op_t;
endpackage

/* File: common/dsp_datapath_regs.svh */
// Constants of the fixed-point datapath: reset values, field positions, encodings
`ifndef DSP_DATAPATH_REGS_SVH
`define DSP_DATAPATH_REGS_SVH
`define ACC_RESET        32'h0000_0000
`define PROD_RESET       32'h0000_0000
`define MCAND_RESET      16'h0000
`define AUX_RESET        16'h0000
`define PTR_RESET        3'h0
`define ACC_HIGH_MSB     31
`define ACC_HIGH_LSB     16
`define ACC_LOW_MSB      15
`define ACC_LOW_LSB      0
`define IN_SHIFT_MAX     5'h10
`define OUT_SHIFT_MAX    3'h7
`define PSHIFT_NONE      2'h0
`define PSHIFT_LEFT1     2'h1
`define PSHIFT_LEFT4     2'h2
`define PSHIFT_RIGHT6    2'h3
`define MULT_LATENCY     1
`endif

/* File: rtl/aux_addr_unit.sv */
// Auxiliary address registers and their address arithmetic unit
`timescale 1ns/1ns
`include "dsp_datapath_regs.svh"
module aux_addr_unit
#(
    parameter int NUM_REGS = 8
)
(
    input  wire logic                   clock,
    input  wire logic                   rst_sync_n,
    input  wire logic                   clk_en,
    input  wire logic                   sync_clear,
    input  wire logic [2:0]             aux_pointer_select,
    input  wire dsp_datapath_pkg::aux_op_t aux_op,
    input  wire logic [15:0]            aux_load_value,
    output logic      [15:0]            current_value,
    output logic      [15:0]            indirect_addr
);
    logic [15:0] aux_reg  [NUM_REGS];
    logic [15:0] aux_next [NUM_REGS];

    assign current_value = aux_reg[aux_pointer_select];
    // Address goes out before any post-modify, as indirect access expects
    assign indirect_addr = aux_reg[aux_pointer_select];

    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            aux_next[i] = aux_reg[i];
        end
        if (sync_clear)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                aux_next[i] = `AUX_RESET;
            end
        end
        else
        begin
            unique case (aux_op)
                dsp_datapath_pkg::AUX_NONE: ;
                dsp_datapath_pkg::AUX_INC:
                    aux_next[aux_pointer_select] = aux_reg[aux_pointer_select] + 16'h0001;
                dsp_datapath_pkg::AUX_DEC:
                    aux_next[aux_pointer_select] = aux_reg[aux_pointer_select] - 16'h0001;
                dsp_datapath_pkg::AUX_LOAD:
                    aux_next[aux_pointer_select] = aux_load_value;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                aux_reg[i] <= `AUX_RESET;
            end
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                aux_reg[i] <= aux_next[i];
            end
        end
    end

    a_aux_load_takes: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && !sync_clear && aux_op == dsp_datapath_pkg::AUX_LOAD
        |=> aux_reg[$past(aux_pointer_select)] == $past(aux_load_value))
        else $error("Auxiliary register load lost");
    // Post-increment must land on the register whose old value went out as address
    a_aux_addr_select: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && !sync_clear && aux_op == dsp_datapath_pkg::AUX_INC
        |=> aux_reg[$past(aux_pointer_select)] == $past(indirect_addr) + 16'h0001)
        else $error("Indirect address not from selected register");
endmodule

/* File: rtl/dsp_cpu_datapath.sv */
// Fixed-point CPU datapath: arithmetic unit, accumulator, shifters, multiplier
// Contract
// - Arithmetic unit works on 32-bit two's complement
// - Operand: data word, immediate, or product
// - Arithmetic unit also does Boolean logic
// - Accumulator captures result, feeds back operand
// - 32-bit accumulator, halves stored separately
// - Input shifter shifts left zero to sixteen
// - Output shifter left 0-7, accumulator untouched
// - Product shifter: none, left1, left4, right6
// - Signed 16x16 multiply, full 32-bit result
// - Multiplicand register operand; result into product register
// - Multiply completes in one cycle
// - Address unit gives indirect data address
// - Eight auxiliary registers, loadable and storable
// - 3-bit pointer selects auxiliary register
// - Input shift zero-fills low, sign-extends optionally
// - Shift select codes 00,01,10,11 mapped
// - Right six always sign-extends; product kept
// - Unsigned multiply treats both operands unsigned
`timescale 1ns/1ns
`include "dsp_datapath_regs.svh"
module dsp_cpu_datapath
(
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic                        sync_clear,
    input  wire logic [15:0]                 data_read_bus,
    input  wire logic [15:0]                 prog_read_bus,
    input  wire dsp_datapath_pkg::operand_src_t operand_src,
    input  wire dsp_datapath_pkg::alu_op_t   alu_op,
    input  wire logic [4:0]                  in_shift_count,
    input  wire logic                        sign_extend_enable,
    input  wire logic [1:0]                  product_shift_select,
    input  wire logic [2:0]                  out_shift_count,
    input  wire logic                        load_multiplicand,
    input  wire logic                        multiply_en,
    input  wire logic                        mult_use_imm,
    input  wire logic                        unsigned_multiply_op,
    input  wire logic [2:0]                  aux_pointer_select,
    input  wire dsp_datapath_pkg::aux_op_t   aux_op,
    input  wire logic                        aux_load_from_imm,
    output logic      [31:0]                 accumulator,
    output logic      [31:0]                 product_reg,
    output logic      [15:0]                 multiplicand_reg,
    output logic      [15:0]                 acc_high_store,
    output logic      [15:0]                 acc_low_store,
    output logic      [15:0]                 aux_store,
    output logic      [15:0]                 data_addr
);
    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [31:0] prod_reg;
    logic [31:0] prod_next;
    logic [15:0] mcand_reg;
    logic [15:0] mcand_next;
    logic [15:0] high_store_reg;
    logic [15:0] high_store_next;
    logic [15:0] low_store_reg;
    logic [15:0] low_store_next;
    logic [15:0] aux_store_reg;
    logic [15:0] aux_store_next;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [15:0] aux_current;
    logic [15:0] aux_addr;
    logic [31:0] scaled_in;
    logic [31:0] scaled_prod;
    logic [31:0] operand;
    logic [31:0] alu_result;
    logic [31:0] out_shifted;
    logic [15:0] mult_b;
    logic [31:0] mult_result;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Counts above sixteen saturate rather than wrap to a small shift
    function automatic logic [31:0] in_shift(input logic [15:0] value,
                                             input logic [4:0]  count,
                                             input logic        sx);
        logic [31:0] ext;
        logic [4:0]  n;
        ext = sx ? {{16{value[15]}}, value} : {16'h0000, value};
        n   = (count > `IN_SHIFT_MAX) ? `IN_SHIFT_MAX : count;
        return ext << n;
    endfunction

    function automatic logic [31:0] prod_shift(input logic [31:0] p,
                                               input logic [1:0]  mode);
        logic [31:0] r;
        r = p;
        unique case (mode)
            `PSHIFT_NONE:   r = p;
            `PSHIFT_LEFT1:  r = p << 1;
            `PSHIFT_LEFT4:  r = p << 4;
            `PSHIFT_RIGHT6: r = $signed(p) >>> 6;
        endcase
        return r;
    endfunction

    assign scaled_in   = in_shift(operand_src == dsp_datapath_pkg::SRC_IMM ?
                                  prog_read_bus : data_read_bus,
                                  in_shift_count, sign_extend_enable);
    assign scaled_prod = prod_shift(prod_reg, product_shift_select);
    assign operand     = (operand_src == dsp_datapath_pkg::SRC_PROD) ? scaled_prod : scaled_in;
    assign out_shifted = acc_reg << out_shift_count;
    assign mult_b      = mult_use_imm ? prog_read_bus : data_read_bus;

    // Both operands widened to 33 bits so one signed multiplier serves both forms
    always_comb
    begin
        logic signed [32:0] a33;
        logic signed [32:0] b33;
        logic signed [65:0] full;
        a33 = unsigned_multiply_op ? $signed({17'h00000, mcand_reg})
                                   : $signed({{17{mcand_reg[15]}}, mcand_reg});
        b33 = unsigned_multiply_op ? $signed({17'h00000, mult_b})
                                   : $signed({{17{mult_b[15]}}, mult_b});
        full = a33 * b33;
        mult_result = full[31:0];
    end

    always_comb
    begin
        unique case (alu_op)
            dsp_datapath_pkg::ALU_PASS: alu_result = operand;
            dsp_datapath_pkg::ALU_ADD:  alu_result = acc_reg + operand;
            dsp_datapath_pkg::ALU_SUB:  alu_result = acc_reg - operand;
            dsp_datapath_pkg::ALU_AND:  alu_result = acc_reg & operand;
            dsp_datapath_pkg::ALU_OR:   alu_result = acc_reg | operand;
            dsp_datapath_pkg::ALU_XOR:  alu_result = acc_reg ^ operand;
            default:                    alu_result = acc_reg;
        endcase
    end

    always_comb
    begin
        acc_next        = alu_result;
        prod_next       = multiply_en ? mult_result : prod_reg;
        mcand_next      = load_multiplicand ? data_read_bus : mcand_reg;
        high_store_next = out_shifted[`ACC_HIGH_MSB:`ACC_HIGH_LSB];
        low_store_next  = out_shifted[`ACC_LOW_MSB:`ACC_LOW_LSB];
        aux_store_next  = aux_current;
        addr_next       = aux_addr;
        if (sync_clear)
        begin
            acc_next   = `ACC_RESET;
            prod_next  = `PROD_RESET;
            mcand_next = `MCAND_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            acc_reg        <= `ACC_RESET;
            prod_reg       <= `PROD_RESET;
            mcand_reg      <= `MCAND_RESET;
            high_store_reg <= 16'h0000;
            low_store_reg  <= 16'h0000;
            aux_store_reg  <= `AUX_RESET;
            addr_reg       <= `AUX_RESET;
        end
        else if (clk_en)
        begin
            acc_reg        <= acc_next;
            prod_reg       <= prod_next;
            mcand_reg      <= mcand_next;
            high_store_reg <= high_store_next;
            low_store_reg  <= low_store_next;
            aux_store_reg  <= aux_store_next;
            addr_reg       <= addr_next;
        end
    end

    aux_addr_unit #(
        .NUM_REGS (8)
    ) u_aux (
        .clock              (clock),
        .rst_sync_n         (rst_sync_reg),
        .clk_en             (clk_en),
        .sync_clear         (sync_clear),
        .aux_pointer_select (aux_pointer_select),
        .aux_op             (aux_op),
        .aux_load_value     (aux_load_from_imm ? prog_read_bus : data_read_bus),
        .current_value      (aux_current),
        .indirect_addr      (aux_addr)
    );

    assign accumulator      = acc_reg;
    assign product_reg      = prod_reg;
    assign multiplicand_reg = mcand_reg;
    assign acc_high_store   = high_store_reg;
    assign acc_low_store    = low_store_reg;
    assign aux_store        = aux_store_reg;
    assign data_addr        = addr_reg;

    a_acc_add_result: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && alu_op == dsp_datapath_pkg::ALU_ADD
        |=> acc_reg == $past(acc_reg) + $past(operand))
        else $error("Accumulator add wrong");
    a_logic_and_result: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && alu_op == dsp_datapath_pkg::ALU_AND
        |=> acc_reg == ($past(acc_reg) & $past(operand)))
        else $error("Accumulator and wrong");
    a_mult_one_cycle: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && multiply_en && !unsigned_multiply_op
        |=> $signed(prod_reg) == $signed($past(mcand_reg)) * $signed($past(mult_b)))
        else $error("Signed product wrong");
    a_mult_unsigned: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && multiply_en && unsigned_multiply_op
        |=> prod_reg == {16'h0000, $past(mcand_reg)} * {16'h0000, $past(mult_b)})
        else $error("Unsigned product wrong");
    a_prod_right_six: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        product_shift_select == `PSHIFT_RIGHT6
        |-> scaled_prod[31:26] == {6{prod_reg[31]}})
        else $error("Right shift not sign extended");
    a_prod_kept: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && !multiply_en |=> $stable(prod_reg))
        else $error("Product register changed without multiply");
    a_store_no_change: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && !sync_clear && alu_op == dsp_datapath_pkg::ALU_HOLD
        |=> acc_reg == $past(acc_reg)
            && {acc_high_store, acc_low_store} == $past(acc_reg) << $past(out_shift_count))
        else $error("Store halves wrong");
    a_in_shift_fill: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        in_shift_count == 5'h08 && !sign_extend_enable && operand_src == dsp_datapath_pkg::SRC_DATA
        |-> scaled_in == {8'h00, data_read_bus, 8'h00})
        else $error("Input shift wrong");
    a_sync_clear: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        clk_en && sync_clear |=> acc_reg == 32'h0 && prod_reg == 32'h0 && mcand_reg == 16'h0)
        else $error("Synchronous clear failed");

    c_mac: cover property (@(posedge clock) multiply_en ##1 alu_op == dsp_datapath_pkg::ALU_ADD
        && operand_src == dsp_datapath_pkg::SRC_PROD);
    c_unsigned: cover property (@(posedge clock) multiply_en && unsigned_multiply_op);
    c_sign_ext: cover property (@(posedge clock) sign_extend_enable && data_read_bus[15]);
    c_aux_load: cover property (@(posedge clock) aux_op == dsp_datapath_pkg::AUX_LOAD);
endmodule

/* File: verification/data_mem_model.sv */
// Data memory and decoder word source facing the datapath read bus
`timescale 1ns/1ns
module data_mem_model
(
    input  wire logic        use_mem,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] direct_word,
    output logic      [15:0] read_word
);
    logic [15:0] mem [16];
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'h0a00 + 16'(i);
    end
    // Only 16 words: indirect addresses fold onto the low four bits
    assign read_word = use_mem ? mem[addr[3:0]] : direct_word;
endmodule

/* File: verification/dsp_cpu_datapath_tb_top.sv */
// Self-checking bench for the fixed-point CPU datapath
`timescale 1ns/1ns
module dsp_cpu_datapath_tb_top;
    logic                           clock;
    logic                           rst_n;
    logic                           clk_en;
    logic                           sync_clear;
    logic                           use_mem;
    logic [15:0]                    tb_word;
    logic [15:0]                    data_read_bus;
    logic [15:0]                    prog_read_bus;
    dsp_datapath_pkg::operand_src_t src;
    dsp_datapath_pkg::alu_op_t      op;
    logic [4:0]                     in_cnt;
    logic                           sx;
    logic [1:0]                     pm;
    logic [2:0]                     out_cnt;
    logic                           ld_mc;
    logic                           mul_en;
    logic                           mul_imm;
    logic                           mul_u;
    logic [2:0]                     ptr;
    dsp_datapath_pkg::aux_op_t      aop;
    logic                           aux_imm;
    logic [31:0]                    acc;
    logic [31:0]                    prod;
    logic [15:0]                    mcand;
    logic [15:0]                    st_hi;
    logic [15:0]                    st_lo;
    logic [15:0]                    aux_st;
    logic [15:0]                    addr;
    int                             mismatches;
    int                             compares;

    dsp_cpu_datapath u_dsp_cpu_datapath
    (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .sync_clear(sync_clear),
        .data_read_bus(data_read_bus), .prog_read_bus(prog_read_bus),
        .operand_src(src), .alu_op(op), .in_shift_count(in_cnt),
        .sign_extend_enable(sx), .product_shift_select(pm), .out_shift_count(out_cnt),
        .load_multiplicand(ld_mc), .multiply_en(mul_en), .mult_use_imm(mul_imm),
        .unsigned_multiply_op(mul_u), .aux_pointer_select(ptr), .aux_op(aop),
        .aux_load_from_imm(aux_imm), .accumulator(acc), .product_reg(prod),
        .multiplicand_reg(mcand), .acc_high_store(st_hi), .acc_low_store(st_lo),
        .aux_store(aux_st), .data_addr(addr)
    );

    data_mem_model u_data_mem_model
    (
        .use_mem(use_mem), .addr(addr), .direct_word(tb_word), .read_word(data_read_bus)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic idle();
        clk_en = 1'b1;
        sync_clear = 1'b0;
        use_mem = 1'b0;
        tb_word = 16'h0000;
        prog_read_bus = 16'h0000;
        src = dsp_datapath_pkg::SRC_DATA;
        op = dsp_datapath_pkg::ALU_HOLD;
        in_cnt = 5'h00;
        sx = 1'b0;
        pm = 2'h0;
        out_cnt = 3'h0;
        ld_mc = 1'b0;
        mul_en = 1'b0;
        mul_imm = 1'b0;
        mul_u = 1'b0;
        ptr = 3'h0;
        aop = dsp_datapath_pkg::AUX_NONE;
        aux_imm = 1'b0;
    endtask

    // Inputs always move 1 ns after the edge so the design samples settled values
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_acc(input logic [31:0] v);
        src = dsp_datapath_pkg::SRC_IMM;
        op = dsp_datapath_pkg::ALU_PASS;
        sx = 1'b0;
        in_cnt = 5'h10;
        prog_read_bus = v[31:16];
        tick();
        op = dsp_datapath_pkg::ALU_OR;
        in_cnt = 5'h00;
        prog_read_bus = v[15:0];
        tick();
        op = dsp_datapath_pkg::ALU_HOLD;
    endtask

    task automatic t_mac();
        set_acc(32'h0000_0010);
        ld_mc = 1'b1;
        tb_word = 16'hfffe;
        tick();
        ld_mc = 1'b0;
        mul_en = 1'b1;
        tb_word = 16'h0003;
        tick();
        chk({16'h0000, mcand}, 32'h0000_fffe);
        chk(prod, 32'hffff_fffa);
        mul_en = 1'b0;
        src = dsp_datapath_pkg::SRC_PROD;
        op = dsp_datapath_pkg::ALU_ADD;
        tick();
        chk(acc, 32'h0000_000a);
        $display("test mac done");
    endtask

    task automatic t_pshift();
        logic [31:0] e [4] = '{32'hffff_fffa, 32'hffff_fff4, 32'hffff_ffa0, 32'hffff_ffff};
        src = dsp_datapath_pkg::SRC_PROD;
        op = dsp_datapath_pkg::ALU_PASS;
        for (int m = 0; m < 4; m++)
        begin
            pm = 2'(m);
            tick();
            chk(acc, e[m]);
            chk(prod, 32'hffff_fffa);
        end
        $display("test product shift done");
    endtask

    task automatic t_inshift();
        int cs [6] = '{0, 1, 8, 15, 16, 20};
        int c;
        logic [31:0] e;
        op = dsp_datapath_pkg::ALU_PASS;
        prog_read_bus = 16'h8001;
        tb_word = 16'h8001;
        // Both operand sources go through the same shifter
        for (int i = 0; i < 12; i++)
        begin
            c = cs[i % 6];
            src = (i % 2 == 0) ? dsp_datapath_pkg::SRC_DATA : dsp_datapath_pkg::SRC_IMM;
            sx = 1'(i / 6);
            in_cnt = 5'(c);
            tick();
            e = {(sx ? 16'hffff : 16'h0000), 16'h8001} << (c > 16 ? 16 : c);
            chk(acc, e);
        end
        $display("test input shift done");
    endtask

    task automatic t_logic();
        dsp_datapath_pkg::alu_op_t ops [6] = '{dsp_datapath_pkg::ALU_AND,
            dsp_datapath_pkg::ALU_OR, dsp_datapath_pkg::ALU_XOR, dsp_datapath_pkg::ALU_SUB,
            dsp_datapath_pkg::ALU_ADD, dsp_datapath_pkg::ALU_HOLD};
        logic [31:0] e;
        set_acc(32'h0f0f_00ff);
        e = 32'h0f0f_00ff;
        src = dsp_datapath_pkg::SRC_DATA;
        sx = 1'b1;
        tb_word = 16'h8f3c;
        for (int i = 0; i < 6; i++)
        begin
            op = ops[i];
            tick();
            case (ops[i])
                dsp_datapath_pkg::ALU_AND: e = e & 32'hffff_8f3c;
                dsp_datapath_pkg::ALU_OR:  e = e | 32'hffff_8f3c;
                dsp_datapath_pkg::ALU_XOR: e = e ^ 32'hffff_8f3c;
                dsp_datapath_pkg::ALU_SUB: e = e - 32'hffff_8f3c;
                dsp_datapath_pkg::ALU_ADD: e = e + 32'hffff_8f3c;
                default:                   e = e;
            endcase
            chk(acc, e);
        end
        $display("test logic done");
    endtask

    task automatic t_store();
        logic [31:0] v;
        set_acc(32'h8123_4567);
        for (int c = 0; c < 8; c++)
        begin
            out_cnt = 3'(c);
            tick();
            v = 32'h8123_4567 << c;
            chk({16'h0000, st_hi}, {16'h0000, v[31:16]});
            chk({16'h0000, st_lo}, {16'h0000, v[15:0]});
            chk(acc, 32'h8123_4567);
        end
        $display("test store done");
    endtask

    task automatic t_unsigned();
        ld_mc = 1'b1;
        tb_word = 16'hffff;
        tick();
        ld_mc = 1'b0;
        mul_en = 1'b1;
        mul_u = 1'b1;
        tick();
        chk(prod, 32'hfffe_0001);
        mul_u = 1'b0;
        mul_imm = 1'b1;
        prog_read_bus = 16'h8000;
        tick();
        chk(prod, 32'h0000_8000);
        $display("test unsigned done");
    endtask

    task automatic t_aux();
        aux_imm = 1'b1;
        aop = dsp_datapath_pkg::AUX_LOAD;
        for (int p = 0; p < 8; p++)
        begin
            ptr = 3'(p);
            prog_read_bus = 16'h0100 + 16'(p);
            tick();
        end
        aop = dsp_datapath_pkg::AUX_NONE;
        for (int p = 7; p >= 0; p--)
        begin
            ptr = 3'(p);
            tick();
            chk({16'h0000, addr}, 32'h0000_0100 + 32'(p));
            chk({16'h0000, aux_st}, 32'h0000_0100 + 32'(p));
        end
        ptr = 3'h2;
        aux_imm = 1'b0;
        aop = dsp_datapath_pkg::AUX_LOAD;
        tb_word = 16'h0005;
        tick();
        aop = dsp_datapath_pkg::AUX_INC;
        tick();
        aop = dsp_datapath_pkg::AUX_NONE;
        use_mem = 1'b1;
        src = dsp_datapath_pkg::SRC_DATA;
        op = dsp_datapath_pkg::ALU_PASS;
        tick();
        chk(acc, 32'h0000_0a05);
        chk({16'h0000, addr}, 32'h0000_0006);
        op = dsp_datapath_pkg::ALU_HOLD;
        use_mem = 1'b0;
        aop = dsp_datapath_pkg::AUX_DEC;
        tick();
        aop = dsp_datapath_pkg::AUX_NONE;
        tick();
        chk({16'h0000, addr}, 32'h0000_0005);
        $display("test aux done");
    endtask

    task automatic t_freeze();
        clk_en = 1'b0;
        ld_mc = 1'b1;
        op = dsp_datapath_pkg::ALU_PASS;
        src = dsp_datapath_pkg::SRC_IMM;
        prog_read_bus = 16'h1234;
        tick(2);
        chk(acc, 32'h0000_0a05);
        chk({16'h0000, mcand}, 32'h0000_ffff);
        clk_en = 1'b1;
        sync_clear = 1'b1;
        tick();
        chk(acc, 32'h0000_0000);
        chk(prod, 32'h0000_0000);
        chk({16'h0000, mcand}, 32'h0000_0000);
        idle();
        ptr = 3'h2;
        tick(2);
        chk({16'h0000, addr}, 32'h0000_0000);
        $display("test freeze and clear done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clock);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        mismatches = 0;
        compares = 0;
        rst_n = 1'b0;
        idle();
        tick(3);
        chk(acc, 32'h0000_0000);
        rst_n = 1'b1;
        tick(3);
        t_mac();
        idle();
        t_pshift();
        idle();
        t_inshift();
        idle();
        t_logic();
        idle();
        t_store();
        idle();
        t_unsigned();
        idle();
        t_aux();
        t_freeze();
        report_and_stop();
    end
endmodule
